/* hdl/eic_pkg.sv */
// Overview of operation
// - set irq1 pending on selected edge/level
// - edge mode: vectoring or software clears irq1
// - level mode: irq1 pending follows active input
// - irq1 type bit: 0 level, 1 edge
// - irq1 active level from polarity bit
// - edge mode: vectoring or software clears irq0
// - level mode: irq0 pending follows active input
// - irq0 type bit: 0 level, 1 edge
// - irq0 active level from polarity bit
// - timer0 counts when run and (not gated or active)
package eic_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [7:0] EIC_CTRL_ADDR   = 8'h00;  // timer_irq_control_reg
  localparam logic [7:0] EIC_CFG_ADDR    = 8'h04;  // ext_irq_config_reg
  localparam logic [7:0] EIC_TMOD_ADDR   = 8'h08;  // gate select bits
  localparam logic [7:0] EIC_STAT_ADDR   = 8'h0C;  // sticky event status
  localparam logic [7:0] EIC_CLR_ADDR    = 8'h10;  // write-one-to-clear status
  localparam logic [7:0] EIC_EN_ADDR     = 8'h14;  // interrupt enable

  // control register field positions
  localparam int EIC_CTRL_TYPE0_BIT = 0;  // ext_irq0_type_select
  localparam int EIC_CTRL_PEND0_BIT = 1;  // ext_irq0_pending
  localparam int EIC_CTRL_TYPE1_BIT = 2;  // ext_irq1_type_select
  localparam int EIC_CTRL_PEND1_BIT = 3;  // ext_irq1_pending
  localparam int EIC_CTRL_RUN0_BIT  = 4;  // timer0_run
  // configuration register field positions
  localparam int EIC_CFG_POL0_BIT   = 3;  // ext_irq0_polarity
  localparam int EIC_CFG_POL1_BIT   = 7;  // ext_irq1_polarity
  // gate register field position
  localparam int EIC_TMOD_TIMER0_GATE_SELECT_BIT = 3;  // timer0_gate_select

  // reset values
  localparam logic [7:0] EIC_CTRL_RST = 8'h00;
  localparam logic [7:0] EIC_CFG_RST  = 8'h00;
  localparam logic [7:0] EIC_TMOD_RST = 8'h00;
  localparam logic [1:0] EIC_STAT_RST = 2'h0;

  // axi responses
  localparam logic [1:0] EIC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] EIC_RESP_SLVERR = 2'h2;

  // one external interrupt channel: configuration in, pending out
  typedef struct packed {
    logic typeEdge;   // 1 edge, 0 level
    logic polHigh;    // 1 active high, 0 active low
    logic vectorAck;  // cpu vectors to this channel
    logic swClear;    // software writes pending to 0
    logic swSet;      // software writes pending to 1
  } eic_chan_ctl_type;

  // axi write side state
  typedef enum logic [1:0] {EIC_W_IDLE, EIC_W_RESP} eic_wstate_type;

endpackage : eic_pkg

/* hdl/eic_sync.sv */
`timescale 1ns/1ps
// three-stage input synchroniser with agreement filter
module eic_sync
  import eic_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pinIn,
  output logic      syncOut
);

  typedef struct packed {
    logic [2:0] stage;  // stage[0] is the metastable catcher
    logic       level;  // filtered level
  } eic_sync_state_type;

  eic_sync_state_type stReg;   // registered state
  eic_sync_state_type stNext;  // next state

  ////////////////////////////////////////////////////////////////////////////////
  // only stage[1] reads stage[0]; level moves when stages 1 and 2 agree
  always_comb begin
    stNext       = stReg;
    stNext.stage = {stReg.stage[1:0], pinIn};
    if (stReg.stage[1] == stReg.stage[2]) begin
      stNext.level = stReg.stage[2];
    end
  end

  // register; reset to the idle high level of an active-low pin so that the
  // default polarity sees no false active level or edge after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stReg <= '1;
    end else begin
      stReg <= stNext;
    end
  end

  assign syncOut = stReg.level;

endmodule : eic_sync

/* hdl/eic_chan.sv */
`timescale 1ns/1ps
// one external interrupt channel: polarity, trigger type, pending flag
module eic_chan
  import eic_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             syncIn,
  input  wire eic_chan_ctl_type ctl,
  output logic                  active,
  output logic                  pending,
  output logic                  edgeEvent
);

  typedef struct packed {
    logic activeDly;  // previous active level
    logic pend;       // pending flag
  } eic_chan_state_type;

  eic_chan_state_type stReg;   // registered state
  eic_chan_state_type stNext;  // next state
  logic               rise;    // one-cycle active transition

  ////////////////////////////////////////////////////////////////////////////////
  // polarity applied to synchronised pin
  assign active = ctl.polHigh ? syncIn : ~syncIn;
  assign rise   = active & ~stReg.activeDly;

  // pending flag update
  always_comb begin
    stNext           = stReg;
    stNext.activeDly = active;
    if (ctl.typeEdge) begin
      // edge mode: clears from vectoring or software, edge wins
      if (ctl.vectorAck || ctl.swClear) begin
        stNext.pend = 1'b0;
      end
      if (ctl.swSet) begin
        stNext.pend = 1'b1;
      end
      if (rise) begin
        stNext.pend = 1'b1;
      end
    end else begin
      // level mode: flag tracks the active input
      stNext.pend = active;
    end
  end

  // register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stReg <= '0;
    end else begin
      stReg <= stNext;
    end
  end

  assign pending   = stReg.pend;
  assign edgeEvent = ctl.typeEdge & rise;

endmodule : eic_chan

/* hdl/eic_top.sv */
`timescale 1ns/1ps
// external interrupt flag control with axi4-lite register access
module eic_top
  import eic_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // external pins
  input  wire logic        extIrq0Input,
  input  wire logic        extIrq1Input,
  // cpu vectoring acknowledges
  input  wire logic        vectorAck0,
  input  wire logic        vectorAck1,
  // core-facing outputs
  output logic             extIrq0Pending,
  output logic             extIrq1Pending,
  output logic             timer0CountEnable,
  output logic             irqOut,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////////
  // block state
  typedef struct packed {
    logic [7:0]     ctrl;      // control bits, pending bits unused here
    logic [7:0]     cfg;       // polarity configuration
    logic [7:0]     tmod;      // gate select
    logic [1:0]     stat;      // sticky events
    logic [1:0]     en;        // interrupt enables
    logic           awHeld;    // write address captured
    logic [7:0]     awAddr;    // captured write address
    logic           wHeld;     // write data captured
    logic [31:0]    wData;     // captured write data
    logic [3:0]     wStrb;     // captured strobes
    eic_wstate_type wState;    // write response state
    logic [1:0]     bResp;     // write response code
    logic           rValid;    // read data valid
    logic [31:0]    rData;     // read data
    logic [1:0]     rResp;     // read response code
  } eic_top_state_type;

  eic_top_state_type stReg;    // registered state
  eic_top_state_type stNext;   // next state

  logic             sync0;     // synchronised irq0 pin
  logic             sync1;     // synchronised irq1 pin
  logic             active0;   // irq0 at its active level
  logic             active1;   // irq1 at its active level
  logic             pend0;     // irq0 pending flag
  logic             pend1;     // irq1 pending flag
  logic             edge0;     // irq0 edge event
  logic             edge1;     // irq1 edge event
  eic_chan_ctl_type ctl0;      // irq0 channel controls
  eic_chan_ctl_type ctl1;      // irq1 channel controls
  logic             doWrite;   // write commits this cycle
  logic             ctrlWr;    // control register written with byte 0
  logic [7:0]       wByte0;    // low byte of committed write

  ////////////////////////////////////////////////////////////////////////////////
  // decode: address maps to a register
  function automatic logic addrMapped(input logic [7:0] a);
    addrMapped = (a == EIC_CTRL_ADDR) || (a == EIC_CFG_ADDR) ||
                 (a == EIC_TMOD_ADDR) || (a == EIC_STAT_ADDR) ||
                 (a == EIC_CLR_ADDR) || (a == EIC_EN_ADDR);
  endfunction : addrMapped

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  eic_sync u_sync0 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pinIn   (extIrq0Input),
    .syncOut (sync0)
  );

  eic_sync u_sync1 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pinIn   (extIrq1Input),
    .syncOut (sync1)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // write commit decode shared by channels and registers
  assign doWrite = stReg.awHeld && stReg.wHeld && (stReg.wState == EIC_W_IDLE);
  assign wByte0  = stReg.wData[7:0];
  assign ctrlWr  = doWrite && (stReg.awAddr == EIC_CTRL_ADDR) && stReg.wStrb[0];

  // channel controls from registers and software writes
  always_comb begin
    ctl0.typeEdge  = stReg.ctrl[EIC_CTRL_TYPE0_BIT];
    ctl0.polHigh   = stReg.cfg[EIC_CFG_POL0_BIT];
    ctl0.vectorAck = vectorAck0;
    ctl0.swClear   = ctrlWr && !wByte0[EIC_CTRL_PEND0_BIT];
    ctl0.swSet     = ctrlWr && wByte0[EIC_CTRL_PEND0_BIT];
    ctl1.typeEdge  = stReg.ctrl[EIC_CTRL_TYPE1_BIT];
    ctl1.polHigh   = stReg.cfg[EIC_CFG_POL1_BIT];
    ctl1.vectorAck = vectorAck1;
    ctl1.swClear   = ctrlWr && !wByte0[EIC_CTRL_PEND1_BIT];
    ctl1.swSet     = ctrlWr && wByte0[EIC_CTRL_PEND1_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt channels
  eic_chan u_chan0 (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .syncIn    (sync0),
    .ctl       (ctl0),
    .active    (active0),
    .pending   (pend0),
    .edgeEvent (edge0)
  );

  eic_chan u_chan1 (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .syncIn    (sync1),
    .ctl       (ctl1),
    .active    (active1),
    .pending   (pend1),
    .edgeEvent (edge1)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // register file and axi4-lite slave
  always_comb begin
    stNext = stReg;

    // write address and data accepted in either order
    if (s_axi_awvalid && !stReg.awHeld) begin
      stNext.awHeld = 1'b1;
      stNext.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !stReg.wHeld) begin
      stNext.wHeld = 1'b1;
      stNext.wData = s_axi_wdata;
      stNext.wStrb = s_axi_wstrb;
    end

    // commit the write, then respond
    if (doWrite) begin
      stNext.awHeld = 1'b0;
      stNext.wHeld  = 1'b0;
      stNext.wState = EIC_W_RESP;
      stNext.bResp  = addrMapped(stReg.awAddr) ? EIC_RESP_OKAY : EIC_RESP_SLVERR;
      if (stReg.wStrb[0]) begin
        case (stReg.awAddr)
          EIC_CTRL_ADDR: begin
            // pending bits live in the channels
            stNext.ctrl = wByte0 & 8'h15;
          end
          EIC_CFG_ADDR: begin
            stNext.cfg = wByte0;
          end
          EIC_TMOD_ADDR: begin
            stNext.tmod = wByte0;
          end
          EIC_CLR_ADDR: begin
            stNext.stat = stReg.stat & ~wByte0[1:0];
          end
          EIC_EN_ADDR: begin
            stNext.en = wByte0[1:0];
          end
          default: begin
            // read-only or unmapped: no storage
          end
        endcase
      end
    end

    // response handshake
    case (stReg.wState)
      EIC_W_RESP: begin
        if (s_axi_bready) begin
          stNext.wState = EIC_W_IDLE;
        end
      end
      default: begin
        // idle: nothing pending
      end
    endcase

    // sticky events: set wins over clear
    if (edge0 || (active0 && !ctl0.typeEdge)) begin
      stNext.stat[0] = 1'b1;
    end
    if (edge1 || (active1 && !ctl1.typeEdge)) begin
      stNext.stat[1] = 1'b1;
    end

    // read channel
    if (stReg.rValid) begin
      if (s_axi_rready) begin
        stNext.rValid = 1'b0;
      end
    end else if (s_axi_arvalid) begin
      stNext.rValid = 1'b1;
      stNext.rResp  = addrMapped(s_axi_araddr) ? EIC_RESP_OKAY : EIC_RESP_SLVERR;
      stNext.rData  = 32'h0000_0000;
      case (s_axi_araddr)
        EIC_CTRL_ADDR: begin
          stNext.rData[7:0] = stReg.ctrl;
          stNext.rData[EIC_CTRL_PEND0_BIT] = pend0;
          stNext.rData[EIC_CTRL_PEND1_BIT] = pend1;
        end
        EIC_CFG_ADDR: begin
          stNext.rData[7:0] = stReg.cfg;
        end
        EIC_TMOD_ADDR: begin
          stNext.rData[7:0] = stReg.tmod;
        end
        EIC_STAT_ADDR: begin
          stNext.rData[1:0] = stReg.stat;
        end
        EIC_EN_ADDR: begin
          stNext.rData[1:0] = stReg.en;
        end
        default: begin
          // clear register and unmapped read as zero
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stReg        <= '0;
      stReg.ctrl   <= EIC_CTRL_RST;
      stReg.cfg    <= EIC_CFG_RST;
      stReg.tmod   <= EIC_TMOD_RST;
      stReg.stat   <= EIC_STAT_RST;
      stReg.wState <= EIC_W_IDLE;
    end else begin
      stReg <= stNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign s_axi_awready = !stReg.awHeld;
  assign s_axi_wready  = !stReg.wHeld;
  assign s_axi_bvalid  = (stReg.wState == EIC_W_RESP);
  assign s_axi_bresp   = stReg.bResp;
  assign s_axi_arready = !stReg.rValid;
  assign s_axi_rvalid  = stReg.rValid;
  assign s_axi_rdata   = stReg.rData;
  assign s_axi_rresp   = stReg.rResp;

  assign extIrq0Pending = pend0;
  assign extIrq1Pending = pend1;
  assign irqOut         = |(stReg.stat & stReg.en);

  // timer 0 enable: run and (ungated or irq0 active)
  assign timer0CountEnable = stReg.ctrl[EIC_CTRL_RUN0_BIT] &&
                             (!stReg.tmod[EIC_TMOD_TIMER0_GATE_SELECT_BIT] || active0);

endmodule : eic_top

/* dv/eic_partner.sv */
`timescale 1ns/1ps
// far side: the two interrupt pins and the cpu vectoring logic
module eic_partner
  import eic_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [1:0] pinLvl, // requested pin levels
  input  wire logic       ackEn,  // cpu services pending flags
  input  wire logic [3:0] ackDly, // cycles pending before vectoring
  input  wire logic [1:0] pend,   // pending flags seen by the cpu
  output logic [1:0]      pinOut, // levels on the pins
  output logic [1:0]      vec     // one-cycle vectoring pulses
);
  logic [3:0] wait_reg [2]; // per channel wait count

  initial vec = 2'h0;
  assign pinOut = pinLvl;

  ////////////////////////////////////////////////////////////
  // vector once a flag has stood for ackDly cycles
  always @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      vec[i] <= ackEn && pend[i] && !vec[i] && wait_reg[i] == ackDly;
      if (!ackEn || !pend[i] || vec[i]) wait_reg[i] <= 4'h0;
      else wait_reg[i] <= wait_reg[i] + 4'h1;
    end
  end
endmodule : eic_partner

/* dv/eic_top_chk.sv */
`timescale 1ns/1ps
// port checker; shadows the control registers from bus writes
module eic_top_chk
  import eic_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        extIrq0Input,
  input wire logic        extIrq1Input,
  input wire logic        vectorAck0,
  input wire logic        extIrq0Pending,
  input wire logic        extIrq1Pending,
  input wire logic        timer0CountEnable,
  input wire logic        irqOut,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid
);
  logic [7:0] addr_reg, data_reg, ctl_reg, cfg_reg, gate_reg, en_reg; // shadows
  logic       strb_reg;         // byte lane 0 written
  logic       quiet, act0, act1; // no response pending; pins active

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  assign quiet = !s_axi_bvalid;
  assign act0  = extIrq0Input == cfg_reg[EIC_CFG_POL0_BIT];
  assign act1  = extIrq1Input == cfg_reg[EIC_CFG_POL1_BIT];

  ////////////////////////////////////////////////////////////
  // capture writes; commit when the response rises
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl_reg  <= 8'h00;
      cfg_reg  <= 8'h00;
      gate_reg <= 8'h00;
      en_reg   <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) addr_reg <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) data_reg <= s_axi_wdata[7:0];
      if (s_axi_wvalid && s_axi_wready) strb_reg <= s_axi_wstrb[0];
      if ($rose(s_axi_bvalid) && s_axi_bresp == EIC_RESP_OKAY && strb_reg) begin
        case (addr_reg)
          EIC_CTRL_ADDR: ctl_reg <= data_reg;
          EIC_CFG_ADDR:  cfg_reg <= data_reg;
          EIC_TMOD_ADDR: gate_reg <= data_reg;
          EIC_EN_ADDR:   en_reg <= data_reg;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////
  chk_lvl_track0: assert property (
    (quiet && !ctl_reg[0] && $stable(act0))[*8] |-> extIrq0Pending == act0)
    else $error("irq0 level flag off");
  chk_lvl_track1: assert property (
    (quiet && !ctl_reg[2] && $stable(act1))[*8] |-> extIrq1Pending == act1)
    else $error("irq1 level flag off");
  chk_edge_hold: assert property (
    quiet && ctl_reg[0] && extIrq0Pending && !vectorAck0 ##1 quiet |-> extIrq0Pending)
    else $error("irq0 edge flag lost");
  chk_ack_clears: assert property (
    (quiet && $stable(act0))[*6] ##0 (ctl_reg[0] && vectorAck0) ##1 quiet
    |-> !extIrq0Pending)
    else $error("irq0 flag kept after vectoring");
  chk_edge_once: assert property (
    (quiet && ctl_reg[0] && $stable(act0) && !extIrq0Pending)[*6] ##1 quiet
    |-> !extIrq0Pending)
    else $error("irq0 flag set without edge");
  chk_run_off: assert property (
    quiet && !ctl_reg[4] |-> !timer0CountEnable) else $error("timer counts while off");
  chk_run_free: assert property (
    quiet && ctl_reg[4] && !gate_reg[3] |-> timer0CountEnable) else $error("timer idle");
  chk_run_gated: assert property (
    (quiet && ctl_reg[4] && gate_reg[3] && $stable(act0))[*8]
    |-> timer0CountEnable == act0) else $error("gated timer wrong");
  chk_irq_mask: assert property (
    quiet && en_reg[1:0] == 2'h0 |-> !irqOut) else $error("masked interrupt raised");

  cover property (ctl_reg[0] && vectorAck0 && extIrq0Pending);
  cover property (irqOut);
  cover property (timer0CountEnable && gate_reg[3]);
endmodule : eic_top_chk

bind eic_top eic_top_chk chk (.*);

/* dv/eic_top_tb.sv */
`timescale 1ns/1ps
// drives the bus and far side; checks flags, timer gate and interrupt
module eic_top_tb
  import eic_pkg::*;
;
  logic        clk, sys_rst, extIrq0Input, extIrq1Input, vectorAck0, vectorAck1;
  logic        extIrq0Pending, extIrq1Pending, timer0CountEnable, irqOut;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, ackDly;
  logic [1:0]  s_axi_bresp, s_axi_rresp, pins;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        ackEn;
  int          error_cnt = 0, comparisons = 0, cycles = 0;

  eic_top dut (.*);
  eic_partner partner (
    .clk    (clk),
    .pinLvl (pins),
    .ackEn  (ackEn),
    .ackDly (ackDly),
    .pend   ({extIrq1Pending, extIrq0Pending}),
    .pinOut ({extIrq1Input, extIrq0Input}),
    .vec    ({vectorAck1, vectorAck0})
  );

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      results();
    end
  end

  task automatic results();
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  ////////////////////////////////////////////////////////////
  // bus write; unmapped place 8'h18 answers with an error
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      aw |= s_axi_awvalid && s_axi_awready;
      w  |= s_axi_wvalid && s_axi_wready;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, (a == 8'h18) ? EIC_RESP_SLVERR : EIC_RESP_OKAY);
  endtask : wr

  // bus read compared against an expected word
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(s_axi_rresp, (a == 8'h18) ? EIC_RESP_SLVERR : EIC_RESP_OKAY);
    check(s_axi_rdata, e);
  endtask : rd

  ////////////////////////////////////////////////////////////
  task automatic tRegs();
    rd(EIC_CTRL_ADDR, {24'h0, EIC_CTRL_RST});
    rd(EIC_CFG_ADDR, {24'h0, EIC_CFG_RST});
    rd(EIC_TMOD_ADDR, {24'h0, EIC_TMOD_RST});
    rd(EIC_STAT_ADDR, {30'h0, EIC_STAT_RST});
    rd(8'h18, 32'h0);
    wr(8'h18, 8'hFF);
    check(irqOut, 1'b0);
  endtask : tRegs

  // level mode at both polarities, active then inactive
  task automatic tLevel();
    for (int p = 0; p < 2; p++) begin
      wr(EIC_CFG_ADDR, p ? 8'h88 : 8'h00);
      wr(EIC_CTRL_ADDR, 8'h00);
      for (int v = 1; v >= 0; v--) begin
        pins <= (v == p) ? 2'h3 : 2'h0;
        idle(8);
        check(extIrq0Pending, v);
        check(extIrq1Pending, v);
        rd(EIC_CTRL_ADDR, v ? 32'h0A : 32'h00);
      end
    end
    wr(EIC_CTRL_ADDR, 8'h0A);
    rd(EIC_CTRL_ADDR, 32'h00);
  endtask : tLevel

  // edge mode: set once, software clear, slow cpu vectoring
  task automatic tEdge();
    wr(EIC_CFG_ADDR, 8'h00);
    pins <= 2'h3;
    wr(EIC_CTRL_ADDR, 8'h05);
    pins <= 2'h0;
    idle(8);
    rd(EIC_CTRL_ADDR, 32'h0F);
    idle(20);
    wr(EIC_CTRL_ADDR, 8'h05);
    idle(8);
    rd(EIC_CTRL_ADDR, 32'h05);
    pins <= 2'h3;
    ackDly <= 4'hC;
    ackEn <= 1'b1;
    idle(8);
    pins <= 2'h0;
    idle(8);
    check({extIrq1Pending, extIrq0Pending}, 2'h3);
    idle(16);
    rd(EIC_CTRL_ADDR, 32'h05);
    ackEn <= 1'b0;
  endtask : tEdge

  // run, gate and input level against the count enable
  task automatic tTimer();
    logic [3:0] row [4];
    row = '{4'b0110, 4'b1001, 4'b1100, 4'b1111};
    for (int i = 0; i < 4; i++) begin
      pins <= {1'b1, ~row[i][1]};
      wr(EIC_CTRL_ADDR, {3'h0, row[i][3], 4'h0});
      wr(EIC_TMOD_ADDR, {4'h0, row[i][2], 3'h0});
      idle(8);
      check(timer0CountEnable, row[i][0]);
    end
  endtask : tTimer

  // status, enable mask and clear of the interrupt line
  task automatic tIrq();
    pins <= 2'h3;
    wr(EIC_CTRL_ADDR, 8'h05);
    wr(EIC_CLR_ADDR, 8'h03);
    wr(EIC_EN_ADDR, 8'h01);
    check(irqOut, 1'b0);
    pins <= 2'h2;
    idle(8);
    check(irqOut, 1'b1);
    rd(EIC_STAT_ADDR, 32'h1);
    wr(EIC_EN_ADDR, 8'h00);
    check(irqOut, 1'b0);
    wr(EIC_EN_ADDR, 8'h01);
    check(irqOut, 1'b1);
    wr(EIC_CLR_ADDR, 8'h01);
    check(irqOut, 1'b0);
    pins <= 2'h0;
    idle(8);
    check(irqOut, 1'b0);
    rd(EIC_STAT_ADDR, 32'h2);
  endtask : tIrq

  ////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    pins = 2'h3;
    ackEn = 1'b0;
    ackDly = 4'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    tRegs();
    tLevel();
    tEdge();
    tTimer();
    tIrq();
    results();
  end
endmodule : eic_top_tb
